// file: rtl/psb_pkg.sv
// Shared constants, types and helpers for the burst configuration block
package psb_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int COL_W = 8;
  localparam int PIN_W = 4 + ADDR_W + DATA_W;
  localparam int CMD_W = 1 + ADDR_W + DATA_W;
  localparam int BUF_DEPTH = 2;

  // Bus configuration register layout
  localparam logic [15:0] BCR_RESET = 16'h1d1f;
  localparam logic [15:0] BCR_WMASK = 16'hfd3f;
  localparam int MODE_BIT = 15;
  localparam int LATTYPE_BIT = 14;
  localparam int LAT_HI = 13;
  localparam int LAT_LO = 11;
  localparam int WAITPOL_BIT = 10;
  localparam int WAITCFG_BIT = 8;
  localparam int DRIVE_HI = 5;
  localparam int DRIVE_LO = 4;
  localparam int WRAP_BIT = 3;
  localparam int BLEN_HI = 2;
  localparam int BLEN_LO = 0;

  // Register select on address bits 19:18
  localparam int REGSEL_HI = 19;
  localparam int REGSEL_LO = 18;
  localparam logic [1:0] REGSEL_REFRESH = 2'h0;
  localparam logic [1:0] REGSEL_IDENT = 2'h1;
  localparam logic [1:0] REGSEL_BUS = 2'h2;

  // Software access sequence
  localparam logic [ADDR_W-1:0] SW_ADDR = 22'h3fffff;
  localparam logic [15:0] SW_SEL_REFRESH = 16'h0000;
  localparam logic [15:0] SW_SEL_BUS = 16'h0001;
  localparam logic [15:0] SW_SEL_IDENT = 16'h0002;

  localparam logic [COL_W-1:0] ROW_LAST = 8'hff;
  localparam logic [3:0] LAT_RESERVED_CLOCKS = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT = 2'b01,
    ST_BURST = 2'b10,
    ST_HOLD = 2'b11
  } psb_state_e;

  // Initial latency in clocks; reserved codes fall back to the default
  function automatic logic [3:0] latency_clocks(input logic [2:0] code);
    case (code)
      3'h0: return 4'h9;
      3'h2: return 4'h3;
      3'h3: return 4'h4;
      3'h4: return 4'h5;
      3'h5: return 4'h6;
      3'h6: return 4'h7;
      default: return LAT_RESERVED_CLOCKS;
    endcase
  endfunction

  // Words per burst; zero means continuous to the row end
  function automatic logic [5:0] burst_words(input logic [2:0] code);
    case (code)
      3'h1: return 6'h04;
      3'h2: return 6'h08;
      3'h3: return 6'h10;
      3'h4: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction

  // Next column, wrapping inside the aligned block when asked
  function automatic logic [COL_W-1:0] next_col(
    input logic [COL_W-1:0] col,
    input logic [5:0] words,
    input logic wrap
  );
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] inc;
    mask = COL_W'(words) - 8'h01;
    inc = col + 8'h01;
    if (wrap && words != 6'h00)
    begin
      return (col & ~mask) | (inc & mask);
    end
    return inc;
  endfunction

endpackage

// file: rtl/psb_buf_if.sv
// Valid/ready carrier between the sequencer and its command buffer
`timescale 1ns/1ps
`default_nettype none
interface psb_buf_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport buffer (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface
`default_nettype wire

// file: rtl/psb_buffer.sv
// Small shift queue; the head entry is itself the output register
`timescale 1ns/1ps
`default_nettype none
module psb_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst,
  psb_buf_if.buffer bus
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] q;
    logic [CW-1:0] cnt;
  } psb_buf_s;

  psb_buf_s r;
  psb_buf_s n;
  logic push;
  logic pop;
  logic [CW-1:0] idx;

  // Ready depends on fill only, so a stalled drain really fills it
  assign bus.in_ready = r.cnt < CW'(DEPTH);
  assign bus.out_valid = r.cnt != '0;
  assign bus.out_data = r.q[0];

  always_comb
  begin
    n = r;
    push = bus.in_valid & bus.in_ready;
    pop = bus.out_valid & bus.out_ready;
    idx = r.cnt - CW'(pop);
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        n.q[i] = r.q[i + 1];
      end
      n.q[DEPTH-1] = '0;
    end
    if (push)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (CW'(i) == idx)
        begin
          n.q[i] = bus.in_data;
        end
      end
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// file: rtl/psb_bus_config.sv
// Bus configuration register with the burst sequencer it governs
//
// Operation
// - Register loads 1d1f at reset before any host access.
// - Select pin with address 19:18 = 10, or software step three 0001.
// - Software third-step data picks refresh 0000, bus 0001, identity 0002.
// - Bit 15: zero synchronous burst, one asynchronous access.
// - Bit 14: zero variable latency (default), one fixed latency.
// - Bits 13:11 latency code: 9,3,4,5,6,7 clocks; 001, 111 reserved.
// - Bit 10 sets hold-off polarity; one means active high, default.
// - Bit 8: zero asserts hold-off during delay, one a cycle ahead.
// - Bit 8 clear: data changes on the same edge as hold-off changes.
// - Bit 8 set: hold-off changes one clock before data changes.
// - Bits 5:4 drive strength: full, half default, quarter; 11 reserved.
// - Bit 3: zero wraps within burst length, one runs sequentially.
// - Bits 2:0 burst length 4, 8, 16, 32 or continuous (111).
// - Write bursts follow the same length and wrap as reads.
// - Continuous bursts run sequentially until the row end.
// - Without wrap a fixed burst stops at the row end.
// - With wrap the address cycles inside the aligned burst block.
`timescale 1ns/1ps
`default_nettype none
module psb_bus_config #(
  parameter int BUF_DEPTH = psb_pkg::BUF_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce_n,
  input wire logic i_adv_n,
  input wire logic i_we_n,
  input wire logic i_config_register_select_pin,
  input wire logic [psb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [psb_pkg::DATA_W-1:0] i_dq,
  output logic [psb_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  output logic o_wait,
  output logic o_wait_oe_n,
  output logic [1:0] o_drive_strength,
  output logic [psb_pkg::DATA_W-1:0] o_bus_config_register,
  input wire logic i_refresh_busy,
  output logic o_arr_valid,
  input wire logic i_arr_ready,
  output logic o_arr_we,
  output logic [psb_pkg::ADDR_W-1:0] o_arr_addr,
  output logic [psb_pkg::DATA_W-1:0] o_arr_wdata,
  input wire logic i_arr_rvalid,
  input wire logic [psb_pkg::DATA_W-1:0] i_arr_rdata
);
  import psb_pkg::*;

  typedef struct packed {
    psb_state_e st;
    logic [PIN_W-1:0] pin_m;
    logic [PIN_W-1:0] pin_s;
    logic ce_d;
    logic adv_d;
    logic [15:0] bus_configuration;
    logic [3:0] lat_cnt;
    logic [ADDR_W-1:0] addr;
    logic [5:0] blen;
    logic [5:0] words_left;
    logic cont;
    logic wrap;
    logic is_write;
    logic is_reg;
    logic reg_bus;
    logic sw_op;
    logic [1:0] sw_step;
    logic [1:0] sw_target;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic wait_pin;
    logic wait_oe_n;
    logic dq_drive;
  } psb_core_s;

  psb_core_s r;
  psb_core_s n;

  logic s_ce_n;
  logic s_adv_n;
  logic s_we_n;
  logic s_cre;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_dq;
  logic start;
  logic ce_rise;
  logic async_mode;
  logic variable_lat;
  logic sw_hit;
  logic sw_reg;
  logic rd_pend;
  logic hold_act;
  logic ev;
  logic [DATA_W-1:0] ev_data;
  logic push_valid;
  logic [CMD_W-1:0] push_data;
  logic wrap_now;

  psb_buf_if #(.W(CMD_W)) cmd_if ();

  psb_buffer #(
    .W(CMD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .bus(cmd_if.buffer)
  );

  // Only the second synchroniser stage is read by the logic
  assign s_ce_n = r.pin_s[PIN_W-1];
  assign s_adv_n = r.pin_s[PIN_W-2];
  assign s_we_n = r.pin_s[PIN_W-3];
  assign s_cre = r.pin_s[PIN_W-4];
  assign s_addr = r.pin_s[ADDR_W+DATA_W-1:DATA_W];
  assign s_dq = r.pin_s[DATA_W-1:0];

  assign start = ~s_ce_n & ~s_adv_n & r.adv_d;
  assign ce_rise = s_ce_n & ~r.ce_d;
  assign async_mode = r.bus_configuration[MODE_BIT];
  assign variable_lat = ~r.bus_configuration[LATTYPE_BIT];
  assign sw_hit = async_mode & ~s_cre & (s_addr == SW_ADDR);
  assign sw_reg = sw_hit & r.sw_step[1];
  assign rd_pend = (r.st == ST_BURST || r.st == ST_HOLD) &
                   ~r.is_write & ~r.is_reg;
  assign wrap_now = r.wrap & ~r.cont;

  assign cmd_if.in_valid = push_valid;
  assign cmd_if.in_data = push_data;
  assign cmd_if.out_ready = i_arr_ready;
  assign o_arr_valid = cmd_if.out_valid;
  assign o_arr_we = cmd_if.out_data[CMD_W-1];
  assign o_arr_addr = cmd_if.out_data[ADDR_W+DATA_W-1:DATA_W];
  assign o_arr_wdata = cmd_if.out_data[DATA_W-1:0];

  // Leading hold-off: data held back one more stage
  assign o_dq = r.bus_configuration[WAITCFG_BIT] ? r.s2 : r.s1;
  assign o_dq_oe_n = ~r.dq_drive;
  assign o_wait = r.wait_pin;
  assign o_wait_oe_n = r.wait_oe_n;
  assign o_drive_strength = r.bus_configuration[DRIVE_HI:DRIVE_LO];
  assign o_bus_config_register = r.bus_configuration;

  always_comb
  begin
    n = r;
    ev = 1'b0;
    ev_data = '0;
    push_valid = 1'b0;
    push_data = '0;
    hold_act = 1'b0;
    n.pin_m = {i_ce_n, i_adv_n, i_we_n, i_config_register_select_pin,
               i_addr, i_dq};
    n.pin_s = r.pin_m;
    n.ce_d = s_ce_n;
    n.adv_d = s_adv_n;

    unique case (r.st)
      ST_IDLE,
      ST_HOLD:
      begin
        if (start)
        begin
          n.addr = s_addr;
          n.is_write = ~s_we_n;
          n.sw_op = sw_hit;
          n.is_reg = s_cre | sw_reg;
          n.reg_bus = s_cre ?
            (s_addr[REGSEL_HI:REGSEL_LO] == REGSEL_BUS) :
            (r.sw_step == 2'h3 && r.sw_target == SW_SEL_BUS[1:0]);
          if (s_cre && !s_we_n &&
              s_addr[REGSEL_HI:REGSEL_LO] == REGSEL_BUS)
          begin
            n.bus_configuration = s_addr[DATA_W-1:0] & BCR_WMASK;
          end
          n.blen = burst_words(r.bus_configuration[BLEN_HI:BLEN_LO]);
          n.words_left = (async_mode || n.is_reg) ? 6'h01 : n.blen;
          n.cont = n.words_left == 6'h00;
          n.wrap = ~r.bus_configuration[WRAP_BIT];
          n.lat_cnt = async_mode ? 4'h0 :
            latency_clocks(r.bus_configuration[LAT_HI:LAT_LO]) - 4'h1;
          n.st = (n.is_reg && n.is_write) ? ST_HOLD : ST_LAT;
        end
      end
      ST_LAT:
      begin
        hold_act = 1'b1;
        if (r.lat_cnt == 4'h0)
        begin
          n.st = ST_BURST;
        end
        // Refresh only stretches variable latency; fixed already covers it
        else if (!(variable_lat && i_refresh_busy && !async_mode))
        begin
          n.lat_cnt = r.lat_cnt - 4'h1;
        end
      end
      ST_BURST:
      begin
        if (r.is_reg)
        begin
          ev = 1'b1;
          ev_data = r.reg_bus ? r.bus_configuration : '0;
          n.st = ST_HOLD;
        end
        else if (cmd_if.in_ready)
        begin
          push_valid = 1'b1;
          push_data = {r.is_write, r.addr, s_dq};
          ev = r.is_write;
          n.addr = {r.addr[ADDR_W-1:COL_W],
                    next_col(r.addr[COL_W-1:0], r.blen, wrap_now)};
          if (!r.cont)
          begin
            n.words_left = r.words_left - 6'h01;
          end
          if ((!r.cont && r.words_left == 6'h01) ||
              (!wrap_now && r.addr[COL_W-1:0] == ROW_LAST))
          begin
            n.st = ST_HOLD;
          end
        end
        hold_act = ~ev;
      end
    endcase

    if (rd_pend && i_arr_rvalid)
    begin
      ev = 1'b1;
      ev_data = i_arr_rdata;
      hold_act = 1'b0;
    end

    // Deselect ends any access; late read returns are dropped
    if (s_ce_n && r.st != ST_IDLE)
    begin
      n.st = ST_IDLE;
    end

    // Write data is taken at deselect, so the host must hold it past then
    if (ce_rise)
    begin
      n.sw_step = 2'h0;
      if (r.sw_op)
      begin
        unique case (r.sw_step)
          2'h0: n.sw_step = r.is_write ? 2'h0 : 2'h1;
          2'h1: n.sw_step = r.is_write ? 2'h0 : 2'h2;
          2'h2:
          begin
            if (r.is_write && s_dq <= SW_SEL_IDENT)
            begin
              n.sw_target = s_dq[1:0];
              n.sw_step = 2'h3;
            end
          end
          2'h3:
          begin
            if (r.is_write && r.sw_target == SW_SEL_BUS[1:0])
            begin
              n.bus_configuration = s_dq & BCR_WMASK;
            end
          end
        endcase
      end
    end

    n.s1 = ev ? ev_data : r.s1;
    n.s2 = r.s1;
    // Polarity follows a register written this cycle, not the old one
    n.wait_pin = n.bus_configuration[WAITPOL_BIT] ? hold_act : ~hold_act;
    n.wait_oe_n = s_ce_n;
    n.dq_drive = ~s_ce_n & ~r.is_write & (r.st != ST_IDLE);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.bus_configuration <= BCR_RESET;
      // Pins leave reset at idle levels so no false edge or drive follows
      r.pin_m[PIN_W-1:PIN_W-3] <= 3'h7;
      r.pin_s[PIN_W-1:PIN_W-3] <= 3'h7;
      r.adv_d <= 1'b1;
      r.ce_d <= 1'b1;
      r.wait_oe_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// file: verif/psb_bus_config_monitor.sv
// Port-level checks for the bus configuration block
`timescale 1ns/1ps
`default_nettype none
module psb_bus_config_monitor
  import psb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce_n,
  input wire logic i_arr_ready,
  input wire logic i_arr_rvalid,
  input wire logic [DATA_W-1:0] i_arr_rdata,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe_n,
  input wire logic o_wait,
  input wire logic o_wait_oe_n,
  input wire logic [1:0] o_drive_strength,
  input wire logic [DATA_W-1:0] o_bus_config_register,
  input wire logic o_arr_valid,
  input wire logic [ADDR_W-1:0] o_arr_addr
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic [15:0] cfg = o_bus_config_register;
  sequence word_direct;
    i_arr_rvalid && !cfg[15] && !cfg[8];
  endsequence
  sequence word_early;
    i_arr_rvalid && !cfg[15] && cfg[8];
  endsequence
  // Hold-off drops first, the word follows one clock later
  sequence flag_then_word;
    o_wait != cfg[10] ##1 o_dq == $past(i_arr_rdata, 2);
  endsequence
  reset_value_a: assert property (disable iff (1'b0)
    $fell(i_rst) |-> cfg == 16'h1d1f) else $error("bad reset value");
  drive_match_a: assert property (
    $stable(cfg) |-> o_drive_strength == cfg[5:4])
    else $error("drive strength off");
  reserved_zero_a: assert property ((cfg & 16'h02c0) == 16'h0)
    else $error("reserved bits set");
  idle_release_a: assert property (
    i_ce_n [*4] |-> o_dq_oe_n && o_wait_oe_n) else $error("pins driven");
  idle_wait_a: assert property (i_ce_n [*4] |-> o_wait != cfg[10])
    else $error("hold-off asserted while idle");
  data_direct_a: assert property (
    word_direct |=> o_dq == $past(i_arr_rdata)) else $error("word late");
  data_early_a: assert property (word_early |=> flag_then_word)
    else $error("hold-off not one clock ahead");
  cmd_hold_a: assert property (
    o_arr_valid && !i_arr_ready |=> o_arr_valid && $stable(o_arr_addr))
    else $error("stalled command changed");
endmodule
`default_nettype wire

// file: verif/psb_array_model.sv
// Behavioural memory array behind the command buffer
`timescale 1ns/1ps
`default_nettype none
module psb_array_model (
  input wire logic i_clock,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic i_we,
  input wire logic [21:0] i_addr,
  output logic o_ready,
  output logic o_rvalid,
  output logic [15:0] o_rdata
);
  wire logic rd = i_valid && o_ready && !i_we;
  assign o_ready = !i_stall;
  initial {o_rvalid, o_rdata} = '0;
  // Idle data toggles so a stale word never passes for a fresh one
  always @(posedge i_clock)
  begin
    o_rvalid <= rd;
    o_rdata <= rd ? ~i_addr[15:0] : ~o_rdata;
  end
endmodule
`default_nettype wire

// file: verif/psb_bus_config_tb.sv
// Self-checking bench for the bus configuration block
`timescale 1ns/1ps
`default_nettype none
module psb_bus_config_tb;
  import psb_pkg::*;
  logic i_clock, i_rst, i_ce_n, i_adv_n, i_we_n, i_refresh_busy;
  logic i_config_register_select_pin, o_dq_oe_n, o_wait, o_wait_oe_n;
  logic o_arr_valid, i_arr_ready, o_arr_we, i_arr_rvalid, arm, wr;
  logic stall = 1'b0;
  logic [ADDR_W-1:0] i_addr, o_arr_addr;
  logic [DATA_W-1:0] i_dq, o_dq, o_bus_config_register, o_arr_wdata;
  logic [DATA_W-1:0] i_arr_rdata;
  logic [1:0] o_drive_strength;
  logic [2:0] cyc = 3'h0;
  int n_fail, checked;
  logic [7:0] got[$], want[$];
  logic [15:0] sel[3] = '{SW_SEL_REFRESH, SW_SEL_IDENT, SW_SEL_BUS};
  logic [15:0] t_cfg[7] = '{16'h1901, 16'h1909, 16'h180f, 16'h1902,
    16'h5901, 16'h1924, 16'h1903};
  logic [21:0] t_adr[7] = '{22'h106, 22'h2fe, 22'h3fa, 22'h40e,
    22'h506, 22'h6ff, 22'h7f5};
  logic [6:0] t_wr = 7'b1010010;

  psb_bus_config i_dut (.*);
  psb_array_model i_arr (.i_clock, .i_stall(stall), .i_valid(o_arr_valid),
    .i_we(o_arr_we), .i_addr(o_arr_addr), .o_ready(i_arr_ready),
    .o_rvalid(i_arr_rvalid), .o_rdata(i_arr_rdata));

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // Array refuses two of every eight cycles so the buffer fills up
  always @(negedge i_clock)
  begin
    cyc <= cyc + 3'h1;
    stall <= cyc[2] && cyc[1];
  end
  always @(posedge i_clock)
    if (arm && o_arr_valid && i_arr_ready)
    begin
      got.push_back(o_arr_addr[7:0]);
      chk({15'h0, o_arr_we}, {15'h0, wr});
      if (wr)
        chk(o_arr_wdata, 16'h5aa5);
    end

  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    checked++;
    if (act !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, act, exp);
    end
  endtask

  function automatic void mk_exp(input logic [15:0] c, input logic [7:0] s);
    int len;
    int n;
    logic [7:0] m;
    logic [7:0] col;
    len = (c[2:0] inside {[3'h1:3'h4]}) ? 2 << c[2:0] : 0;
    m = (len != 0 && !c[3]) ? 8'(len - 1) : 8'hff;
    n = (len == 0 || (c[3] && 256 - s < len)) ? 256 - s : len;
    col = s;
    want.delete();
    repeat (n)
    begin
      want.push_back(col);
      col = (col & ~m) | ((col + 8'h01) & m);
    end
  endfunction

  // Refresh collision at every start; fixed latency must ride over it
  task automatic op(input logic w, input logic c, input logic [21:0] a,
    input logic [15:0] d, input int hold);
    @(negedge i_clock);
    {i_ce_n, i_adv_n, i_we_n, i_config_register_select_pin} = {2'b00, w, c};
    {i_addr, i_dq, i_refresh_busy} = {a, d, 1'b1};
    repeat (5) @(negedge i_clock);
    i_refresh_busy = 1'b0;
    repeat (hold) @(negedge i_clock);
    {i_ce_n, i_adv_n} = 2'b11;
    repeat (4) @(negedge i_clock);
  endtask

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    {i_ce_n, i_adv_n, i_we_n, i_rst} = 4'hf;
    {i_config_register_select_pin, i_refresh_busy, arm} = 3'h0;
    {i_addr, i_dq, wr} = '0;
    n_fail = 0;
    checked = 0;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    chk(o_bus_config_register, 16'h1d1f);
    chk({14'h0, o_drive_strength}, 16'h0001);
    op(1'b0, 1'b1, {6'h00, 16'h0010}, 16'h0, 12);
    chk(o_bus_config_register, 16'h1d1f);
    // Software steps only count in asynchronous mode
    op(1'b0, 1'b1, {6'h08, 16'h9d1f}, 16'h0, 12);
    chk(o_bus_config_register, 16'h9d1f);
    foreach (sel[s])
    begin
      for (int i = 0; i < 4; i++)
        op(i < 2 || (i == 3 && s < 2), 1'b0, SW_ADDR,
          i == 2 ? sel[s] : 16'h1901, 5);
      chk(o_bus_config_register, s == 2 ? 16'h1901 : 16'h9d1f);
    end
    foreach (t_cfg[k])
    begin
      op(1'b0, 1'b1, {6'h08, t_cfg[k]}, 16'h0, 12);
      chk(o_bus_config_register, t_cfg[k]);
      chk({14'h0, o_drive_strength}, {14'h0, t_cfg[k][5:4]});
      // Read back through the select pin; the word stays on the data pins
      op(1'b1, 1'b1, {6'h08, 16'h0}, 16'h0, 12);
      chk(o_dq, t_cfg[k]);
      mk_exp(t_cfg[k], t_adr[k][7:0]);
      wr = t_wr[k];
      got.delete();
      arm = 1'b1;
      op(~wr, 1'b0, t_adr[k], 16'h5aa5, 70);
      arm = 1'b0;
      chk(16'(got.size()), 16'(want.size()));
      foreach (want[j])
        chk({8'h0, got[j]}, {8'h0, want[j]});
    end
    wrap_up();
  end

  initial
  begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule

bind psb_bus_config psb_bus_config_monitor i_mon (.*);
`default_nettype wire
